// ---- core/ssf_gating.sv ----
`timescale 1ns/1ps

// Contract
// R1: Bitmaps are 64 bits; bit 0 float, bit 1 vector SIMD, bit 2 wide.
// R2: Bitmap bits 63 to 3 are reserved and name no component.
// R3: Save and restore take their instruction mask from data and accumulator.
// R4: Save and restore skip every component clear in the enable mask.
// R5: Gated component registers stay unmodified while their enable is clear.
// R6: Feature instructions raise invalid-opcode unless fully enabled.
// R7: With the OS save-enable bit clear, all gated enables act as clear.
// R8: Legacy float and vector SIMD state and instructions are never gated.
// R9: Leaf 1 count bit 26 reports support; without it leaf 0DH is empty.
// R10: OS save-enable bit can be set only when support is reported.
// R11: Leaf 0DH sub-function is chosen by the count register.
// R12: Sub-function 0 gives the manageable bitmap; only its bits are settable.
// R13: Sub-function 0 count register gives the full save-area size.
// R14: Sub-function 0 base register gives the size for the current mask.
// R15: Sub-function 1 bit 0 reports optimized save; if 0 it faults.
// R16: Sub-function i above 1 returns component size and offset.
// R17: Unsupported component sub-functions return zero in all four registers.
// R18: Mask bit 0 always reads 1; writing it 0 faults.
// R19: Writing bits 2:1 as 10b raises the general-protection fault.
// R20: Mask writes need OS save-enable and privilege 0, else fault.
// R21: After reset the mask holds only bit 0.
// R22: Effective enable is the OS bit ANDed with the component mask bit.
module ssf_gating
   import ssf_pkg::*;
#(
   parameter logic        HAS_SUPPORT = 1'b1,
   parameter logic        HAS_OPT     = 1'b1,
   parameter logic [63:0] SUPPORTED   = 64'h0000_0000_0000_0007
)(
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                req_valid_in,
   input  wire logic [3:0]          req_op_in,
   input  wire logic [1:0]          cpl_in,
   input  wire logic [31:0]         acc_in,
   input  wire logic [31:0]         cnt_in,
   input  wire logic [31:0]         data_in,
   input  wire logic [NUM_COMP-1:0] comp_wr_req_in,
   output logic                     resp_valid_out,
   output logic                     ud_fault_out,
   output logic                     gp_fault_out,
   output logic      [31:0]         acc_out,
   output logic      [31:0]         base_out,
   output logic      [31:0]         cnt_out,
   output logic      [31:0]         data_out,
   output logic      [MASK_W-1:0]   op_mask_out,
   output logic      [MASK_W-1:0]   enable_mask_out,
   output logic                     os_enable_out,
   output logic      [NUM_COMP-1:0] eff_enable_out,
   output logic      [NUM_COMP-1:0] comp_wr_ok_out
);

   // ======================================================
   // State
   // ======================================================
   logic [MASK_W-1:0]   mask_r,     mask_nxt;
   logic                os_r,       os_nxt;
   logic                resp_r,     resp_nxt;
   logic                ud_r,       ud_nxt;
   logic                gp_r,       gp_nxt;
   logic [31:0]         acc_r,      acc_nxt;
   logic [31:0]         base_r,     base_nxt;
   logic [31:0]         cnt_r,      cnt_nxt;
   logic [31:0]         data_r,     data_nxt;
   logic [MASK_W-1:0]   sel_r,      sel_nxt;
   logic [NUM_COMP-1:0] eff_r,      eff_nxt;
   logic [NUM_COMP-1:0] wr_ok_r,    wr_ok_nxt;

   ssf_op_t             op;
   logic [MASK_W-1:0]   src_mask;
   logic [MASK_W-1:0]   instr_mask;
   logic [NUM_COMP-1:0] eff_now;
   logic                bad_mask;
   logic [31:0]         q_acc;
   logic [31:0]         q_base;
   logic [31:0]         q_cnt;
   logic [31:0]         q_data;

   assign op         = ssf_op_t'(req_op_in);
   assign src_mask   = {data_in, acc_in};
   assign instr_mask = {data_in, acc_in}; // R3

   // ======================================================
   // Effective enables
   // ======================================================
   always_comb begin
      // Legacy components never depend on the OS bit or mask // R8
      eff_now[COMP_FLOAT] = 1'b1;
      eff_now[COMP_SIMD]  = 1'b1;
      eff_now[COMP_WIDE]  = os_r & mask_r[COMP_WIDE]; // R7 R22
   end

   // Reserved, unsupported, bit 0 clear or wide without SIMD all fault
   always_comb begin
      bad_mask = 1'b0;
      if (!src_mask[COMP_FLOAT]) begin // R18
         bad_mask = 1'b1;
      end
      if (src_mask[COMP_WIDE:COMP_SIMD] == WIDE_NO_SIMD) begin // R19
         bad_mask = 1'b1;
      end
      if ((src_mask & ~(SUPPORTED & MASK_DEFINED)) != 64'h0) begin // R2 R12
         bad_mask = 1'b1;
      end
   end

   ssf_query #(
      .HAS_SUPPORT (HAS_SUPPORT),
      .HAS_OPT     (HAS_OPT),
      .SUPPORTED   (SUPPORTED)
   ) u_query (
      .leaf_in  (acc_in),
      .sub_in   (cnt_in),
      .mask_in  (mask_r),
      .os_en_in (os_r),
      .acc_out  (q_acc),
      .base_out (q_base),
      .cnt_out  (q_cnt),
      .data_out (q_data)
   );

   // ======================================================
   // Request handling
   // ======================================================
   always_comb begin
      mask_nxt  = mask_r;
      os_nxt    = os_r;
      resp_nxt  = req_valid_in;
      ud_nxt    = 1'b0;
      gp_nxt    = 1'b0;
      acc_nxt   = 32'h0000_0000;
      base_nxt  = 32'h0000_0000;
      cnt_nxt   = 32'h0000_0000;
      data_nxt  = 32'h0000_0000;
      sel_nxt   = 64'h0;
      eff_nxt   = eff_now;
      // Modification of gated state follows the effective enable // R5
      wr_ok_nxt = comp_wr_req_in & eff_now;
      if (req_valid_in) begin
         case (op)
            OP_QUERY: begin
               acc_nxt  = q_acc;
               base_nxt = q_base;
               cnt_nxt  = q_cnt;
               data_nxt = q_data;
            end
            OP_READ_MASK: begin
               if (!os_r || !HAS_SUPPORT) begin
                  ud_nxt = 1'b1;
               end else begin
                  acc_nxt  = mask_r[31:0];
                  data_nxt = mask_r[63:32];
               end
            end
            OP_WRITE_MASK: begin
               if (!os_r || !HAS_SUPPORT) begin // R20
                  ud_nxt = 1'b1;
               end else if (cpl_in != 2'h0) begin // R20
                  gp_nxt = 1'b1;
               end else if (bad_mask) begin // R18 R19
                  gp_nxt = 1'b1;
               end else begin
                  mask_nxt = src_mask; // R12
               end
            end
            OP_SAVE,
            OP_RESTORE: begin
               if (!os_r || !HAS_SUPPORT) begin // R7
                  ud_nxt = 1'b1;
               end else begin
                  sel_nxt = instr_mask & mask_r; // R4
               end
            end
            OP_OPT_SAVE: begin
               if (!os_r || !HAS_SUPPORT || !HAS_OPT) begin // R15
                  ud_nxt = 1'b1;
               end else begin
                  sel_nxt = instr_mask & mask_r; // R4
               end
            end
            OP_SET_CTRL: begin
               if (acc_in[OS_ENABLE_BIT] && !HAS_SUPPORT) begin // R10
                  gp_nxt = 1'b1;
               end else begin
                  os_nxt = acc_in[OS_ENABLE_BIT];
               end
            end
            OP_WIDE_INSTR: begin
               // Both wide and SIMD components must be enabled // R6
               if (!(os_r && mask_r[COMP_WIDE] && mask_r[COMP_SIMD])) begin
                  ud_nxt = 1'b1;
               end
            end
            OP_LEGACY_INSTR: begin
               ud_nxt = 1'b0; // R8
            end
            default: begin
               ud_nxt = 1'b0;
            end
         endcase
      end
      // Bit 0 is hard-wired and reserved bits stay clear // R1 R2 R18
      mask_nxt[COMP_FLOAT]    = 1'b1;
      mask_nxt[MASK_W-1:NUM_COMP] = '0;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mask_r  <= MASK_RESET; // R21
         os_r    <= 1'b0;
         resp_r  <= 1'b0;
         ud_r    <= 1'b0;
         gp_r    <= 1'b0;
         acc_r   <= 32'h0000_0000;
         base_r  <= 32'h0000_0000;
         cnt_r   <= 32'h0000_0000;
         data_r  <= 32'h0000_0000;
         sel_r   <= 64'h0;
         eff_r   <= 3'h3;
         wr_ok_r <= 3'h0;
      end else begin
         mask_r  <= mask_nxt;
         os_r    <= os_nxt;
         resp_r  <= resp_nxt;
         ud_r    <= ud_nxt;
         gp_r    <= gp_nxt;
         acc_r   <= acc_nxt;
         base_r  <= base_nxt;
         cnt_r   <= cnt_nxt;
         data_r  <= data_nxt;
         sel_r   <= sel_nxt;
         eff_r   <= eff_nxt;
         wr_ok_r <= wr_ok_nxt;
      end
   end

   assign resp_valid_out  = resp_r;
   assign ud_fault_out    = ud_r;
   assign gp_fault_out    = gp_r;
   assign acc_out         = acc_r;
   assign base_out        = base_r;
   assign cnt_out         = cnt_r;
   assign data_out        = data_r;
   assign op_mask_out     = sel_r;
   assign enable_mask_out = mask_r;
   assign os_enable_out   = os_r;
   assign eff_enable_out  = eff_r;
   assign comp_wr_ok_out  = wr_ok_r;

   // ======================================================
   // Checks
   // ======================================================
   chk_mask_bit0: assert property (@(posedge clk_in) // R18
      disable iff (rst_in) mask_r[COMP_FLOAT])
      else $error("enable mask bit 0 is clear");

   chk_reserved_zero: assert property (@(posedge clk_in) // R2
      disable iff (rst_in) mask_r[MASK_W-1:NUM_COMP] == '0)
      else $error("reserved mask bits set");

   chk_wide_simd: assert property (@(posedge clk_in) // R19
      disable iff (rst_in) mask_r[COMP_WIDE] |-> mask_r[COMP_SIMD])
      else $error("wide enabled without simd");

   chk_gp_priv: assert property (@(posedge clk_in) disable iff (rst_in) // R20
      (req_valid_in && op == OP_WRITE_MASK && os_r && cpl_in != 2'h0)
      |=> (gp_r && resp_r && mask_r == $past(mask_r)))
      else $error("unprivileged mask write not faulted");

   chk_save_subset: assert property (@(posedge clk_in) // R4
      disable iff (rst_in)
      (req_valid_in && op == OP_SAVE && os_r)
      |=> (sel_r == ($past(instr_mask) & $past(mask_r))))
      else $error("save selects a disabled component");

   chk_os_support: assert property (@(posedge clk_in) // R10
      disable iff (rst_in) os_r |-> HAS_SUPPORT)
      else $error("os enable set without support");

   chk_ud_no_os: assert property (@(posedge clk_in) disable iff (rst_in) // R7
      (req_valid_in && op == OP_RESTORE && !os_r) |=> (ud_r && sel_r == '0))
      else $error("restore ran with os enable clear");

   chk_wide_ud: assert property (@(posedge clk_in) disable iff (rst_in) // R6
      (req_valid_in && op == OP_WIDE_INSTR && !eff_now[COMP_WIDE])
      |=> ud_r)
      else $error("wide instruction not faulted");

   chk_legacy_ok: assert property (@(posedge clk_in) // R8
      disable iff (rst_in)
      (req_valid_in && op == OP_LEGACY_INSTR) |=> (!ud_r && !gp_r))
      else $error("legacy instruction faulted");

   chk_wr_gate: assert property (@(posedge clk_in) disable iff (rst_in) // R5
      comp_wr_ok_out[COMP_WIDE]
      |-> ($past(os_r) && $past(mask_r[COMP_WIDE])))
      else $error("gated component modified while disabled");

   chk_write_off: assert property (@(posedge clk_in) // R20
      disable iff (rst_in)
      (req_valid_in && op == OP_WRITE_MASK && !os_r)
      |=> (ud_r && !gp_r && mask_r == $past(mask_r)))
      else $error("mask write with os enable clear not refused");

   chk_wide_eff: assert property (@(posedge clk_in) // R22
      disable iff (rst_in)
      eff_r[COMP_WIDE] == ($past(os_r) && $past(mask_r[COMP_WIDE])))
      else $error("wide effective enable wrong");

endmodule

// ---- core/ssf_pkg.sv ----
package ssf_pkg;

   // ======================================================
   // Component indices and mask layout
   // ======================================================
   localparam int          MASK_W        = 64;
   localparam int          COMP_FLOAT    = 0;
   localparam int          COMP_SIMD     = 1;
   localparam int          COMP_WIDE     = 2;
   localparam int          NUM_COMP      = 3;
   localparam logic [63:0] MASK_RESET    = 64'h0000_0000_0000_0001;
   localparam logic [63:0] MASK_DEFINED  = 64'h0000_0000_0000_0007;
   localparam logic [1:0]  WIDE_NO_SIMD  = 2'h2;

   // ======================================================
   // Control register and query bit positions, leaves and sub-functions
   // ======================================================
   localparam int          OS_ENABLE_BIT = 18;
   localparam int          SUPPORT_BIT   = 26;
   localparam int          OS_REPORT_BIT = 27;
   localparam logic [31:0] LEAF_BASIC    = 32'h0000_0001;
   localparam logic [31:0] LEAF_STATE    = 32'h0000_000d;
   localparam logic [31:0] SUB_MAIN      = 32'h0000_0000;
   localparam logic [31:0] SUB_OPT       = 32'h0000_0001;

   // ======================================================
   // Save-area sizes and offset in bytes
   // ======================================================
   localparam logic [31:0] LEGACY_BYTES  = 32'h0000_0240;
   localparam logic [31:0] WIDE_BYTES    = 32'h0000_0100;
   localparam logic [31:0] WIDE_OFFSET   = 32'h0000_0240;

   // ======================================================
   // Request codes
   // ======================================================
   typedef enum logic [3:0] {
      OP_IDLE         = 4'h0,
      OP_QUERY        = 4'h1,
      OP_READ_MASK    = 4'h2,
      OP_WRITE_MASK   = 4'h3,
      OP_SAVE         = 4'h4,
      OP_OPT_SAVE     = 4'h5,
      OP_RESTORE      = 4'h6,
      OP_SET_CTRL     = 4'h7,
      OP_WIDE_INSTR   = 4'h8,
      OP_LEGACY_INSTR = 4'h9
   } ssf_op_t;

endpackage

// ---- core/ssf_query.sv ----
`timescale 1ns/1ps

module ssf_query
   import ssf_pkg::*;
#(
   parameter logic        HAS_SUPPORT = 1'b1,
   parameter logic        HAS_OPT     = 1'b1,
   parameter logic [63:0] SUPPORTED   = 64'h0000_0000_0000_0007
)(
   input  wire logic [31:0] leaf_in,
   input  wire logic [31:0] sub_in,
   input  wire logic [63:0] mask_in,
   input  wire logic        os_en_in,
   output logic      [31:0] acc_out,
   output logic      [31:0] base_out,
   output logic      [31:0] cnt_out,
   output logic      [31:0] data_out
);

   logic [31:0] max_size;
   logic [31:0] cur_size;

   always_comb begin
      max_size = LEGACY_BYTES;
      cur_size = LEGACY_BYTES;
      if (SUPPORTED[COMP_WIDE]) begin
         max_size = WIDE_OFFSET + WIDE_BYTES;
      end
      // Follows the live mask so software sees the size change at once
      if (mask_in[COMP_WIDE]) begin // R14
         cur_size = WIDE_OFFSET + WIDE_BYTES;
      end
   end

   always_comb begin
      acc_out  = 32'h0000_0000;
      base_out = 32'h0000_0000;
      cnt_out  = 32'h0000_0000;
      data_out = 32'h0000_0000;
      if (leaf_in == LEAF_BASIC) begin
         cnt_out[SUPPORT_BIT]   = HAS_SUPPORT; // R9
         cnt_out[OS_REPORT_BIT] = os_en_in;
      end else if (leaf_in == LEAF_STATE && HAS_SUPPORT) begin // R9 R11
         if (sub_in == SUB_MAIN) begin
            acc_out  = SUPPORTED[31:0]; // R12
            data_out = SUPPORTED[63:32];
            cnt_out  = max_size; // R13
            base_out = cur_size; // R14
         end else if (sub_in == SUB_OPT) begin
            acc_out[0] = HAS_OPT; // R15
         end else if (sub_in < 32'h0000_0040 && SUPPORTED[sub_in[5:0]]) begin
            if (sub_in[5:0] == 6'h02) begin // R16
               acc_out  = WIDE_BYTES;
               base_out = WIDE_OFFSET;
            end
         end
         // Unsupported components fall through to all zeros // R17
      end
   end

endmodule

// ---- dv/ssf_gating_tb.sv ----
`timescale 1ns/1ps

module ssf_gating_tb;
   import ssf_pkg::*;

   // ======================================================
   // Signals
   // ======================================================
   logic          clk_in;
   logic          rst_in;
   logic          req_valid_in;
   logic [3:0]    req_op_in;
   logic [1:0]    cpl_in;
   logic [31:0]   acc_in;
   logic [31:0]   cnt_in;
   logic [31:0]   data_in;
   logic [2:0]    comp_wr_req_in;
   logic          resp_valid_out;
   logic          ud_fault_out;
   logic          gp_fault_out;
   logic [31:0]   acc_out;
   logic [31:0]   base_out;
   logic [31:0]   cnt_out;
   logic [31:0]   data_out;
   logic [63:0]   op_mask_out;
   logic [63:0]   enable_mask_out;
   logic          os_enable_out;
   logic [2:0]    eff_enable_out;
   logic [2:0]    comp_wr_ok_out;
   int            fails;
   int            check_count;
   logic [63:0]   m_mask;

   ssf_gating DUT (
      .clk_in          (clk_in),
      .rst_in          (rst_in),
      .req_valid_in    (req_valid_in),
      .req_op_in       (req_op_in),
      .cpl_in          (cpl_in),
      .acc_in          (acc_in),
      .cnt_in          (cnt_in),
      .data_in         (data_in),
      .comp_wr_req_in  (comp_wr_req_in),
      .resp_valid_out  (resp_valid_out),
      .ud_fault_out    (ud_fault_out),
      .gp_fault_out    (gp_fault_out),
      .acc_out         (acc_out),
      .base_out        (base_out),
      .cnt_out         (cnt_out),
      .data_out        (data_out),
      .op_mask_out     (op_mask_out),
      .enable_mask_out (enable_mask_out),
      .os_enable_out   (os_enable_out),
      .eff_enable_out  (eff_enable_out),
      .comp_wr_ok_out  (comp_wr_ok_out)
   );

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // ======================================================
   // Helpers
   // ======================================================
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [127:0] seen,
                      input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // One request every two cycles; results read while they stand
   task automatic do_req(input ssf_op_t op, input logic [31:0] a,
                         input logic [31:0] c, input logic [31:0] d,
                         input logic [1:0] p);
      @(posedge clk_in);
      #1;
      req_valid_in = 1'b1;
      req_op_in    = op;
      acc_in       = a;
      cnt_in       = c;
      data_in      = d;
      cpl_in       = p;
      @(posedge clk_in);
      #1;
      req_valid_in = 1'b0;
      chk("resp_valid", resp_valid_out, 1'b1);
   endtask

   task automatic flt(input logic ud, input logic gp);
      chk("ud_fault", ud_fault_out, ud);
      chk("gp_fault", gp_fault_out, gp);
   endtask

   function automatic logic legal(input logic [63:0] v);
      return v[0] && v[2:1] != WIDE_NO_SIMD && (v & ~MASK_DEFINED) == 0;
   endfunction

   function automatic logic [127:0] exp_q(input logic [31:0] s,
                                          input logic [63:0] m);
      logic [31:0] cur;
      cur = m[2] ? LEGACY_BYTES + WIDE_BYTES : LEGACY_BYTES;
      case (s)
         32'h0: return {32'h7, cur, LEGACY_BYTES + WIDE_BYTES, 32'h0};
         32'h1: return {32'h1, 96'h0};
         32'h2: return {WIDE_BYTES, WIDE_OFFSET, 64'h0};
         default: return 128'h0;
      endcase
   endfunction

   task automatic query(input logic [31:0] s);
      do_req(OP_QUERY, LEAF_STATE, s, 32'h0, 2'h0);
      chk("query", {acc_out, base_out, cnt_out, data_out},
          exp_q(s, m_mask));
   endtask

   task automatic reset_dut();
      rst_in = 1'b1;
      repeat (12) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      m_mask = MASK_RESET;
      chk("mask_rst", enable_mask_out, MASK_RESET);
      chk("os_rst", os_enable_out, 1'b0);
      chk("eff_rst", eff_enable_out, 3'b011);
   endtask

   // ======================================================
   // Main sequence
   // ======================================================
   initial begin
      logic [31:0] a;
      logic [31:0] d;
      logic        ok;
      int          r;
      rst_in = 1'b1;
      req_valid_in = 1'b0;
      req_op_in = OP_IDLE;
      cpl_in = 2'h0;
      acc_in = 32'h0;
      cnt_in = 32'h0;
      data_in = 32'h0;
      comp_wr_req_in = 3'h0;
      fails = 0;
      check_count = 0;
      void'($urandom(32'h8ba5));
      reset_dut();
      do_req(OP_QUERY, LEAF_BASIC, 32'h0, 32'h0, 2'h0);
      chk("support", cnt_out, 32'h1 << SUPPORT_BIT);
      // Feature set still off: gated ops fault, legacy runs
      do_req(OP_WRITE_MASK, 32'h3, 32'h0, 32'h0, 2'h0);
      flt(1'b1, 1'b0);
      do_req(OP_SAVE, 32'h7, 32'h0, 32'h0, 2'h0);
      flt(1'b1, 1'b0);
      do_req(OP_LEGACY_INSTR, 32'h0, 32'h0, 32'h0, 2'h3);
      flt(1'b0, 1'b0);
      do_req(OP_SET_CTRL, 32'h1 << OS_ENABLE_BIT, 32'h0, 32'h0, 2'h0);
      chk("os_set", os_enable_out, 1'b1);
      do_req(OP_QUERY, LEAF_BASIC, 32'h0, 32'h0, 2'h0);
      chk("os_report", cnt_out[OS_REPORT_BIT], 1'b1);
      query(32'h0);
      // Illegal writes leave the mask alone
      do_req(OP_WRITE_MASK, 32'h7, 32'h0, 32'h0, 2'h3);
      flt(1'b0, 1'b1);
      do_req(OP_WRITE_MASK, 32'h6, 32'h0, 32'h0, 2'h0);
      flt(1'b0, 1'b1);
      do_req(OP_WRITE_MASK, 32'h5, 32'h0, 32'h0, 2'h0);
      flt(1'b0, 1'b1);
      do_req(OP_WRITE_MASK, 32'h7, 32'h0, 32'h8000_0000, 2'h0);
      flt(1'b0, 1'b1);
      chk("mask_keep", enable_mask_out, MASK_RESET);
      do_req(OP_WIDE_INSTR, 32'h0, 32'h0, 32'h0, 2'h0);
      flt(1'b1, 1'b0);
      // Random traffic with a tracked mask
      for (int i = 0; i < 80; i++) begin
         r = $urandom_range(0, 4);
         a = ($urandom_range(0, 3) == 0) ? $urandom : $urandom_range(0, 7);
         d = ($urandom_range(0, 5) == 0) ? $urandom : 32'h0;
         case (r)
            0: begin
               ok = legal({d, a});
               do_req(OP_WRITE_MASK, a, 32'h0, d, 2'h0);
               flt(1'b0, !ok);
               if (ok) begin
                  m_mask = {d, a};
               end
               chk("mask", enable_mask_out, m_mask);
            end
            1: begin
               do_req(ssf_op_t'(OP_SAVE + $urandom_range(0, 2)), a,
                      32'h0, $urandom, 2'h0);
               chk("op_mask", op_mask_out, {data_in, a} & m_mask);
            end
            2: query($urandom_range(0, 5));
            3: begin
               do_req(OP_WIDE_INSTR, 32'h0, 32'h0, 32'h0, 2'h0);
               flt(!(m_mask[2] & m_mask[1]), 1'b0);
            end
            default: begin
               do_req(OP_READ_MASK, 32'h0, 32'h0, 32'h0, 2'h2);
               chk("read", {data_out, acc_out}, m_mask);
               comp_wr_req_in = 3'($urandom);
               repeat (2) @(posedge clk_in);
               #1;
               chk("eff", eff_enable_out, {m_mask[2], 2'b11});
               chk("wr_ok", comp_wr_ok_out,
                   comp_wr_req_in & {m_mask[2], 2'b11});
            end
         endcase
      end
      // Turning the OS bit off gates the wide component and restore again; legacy stays on
      do_req(OP_WRITE_MASK, 32'h7, 32'h0, 32'h0, 2'h0);
      m_mask = 64'h7;
      do_req(OP_SET_CTRL, 32'h0, 32'h0, 32'h0, 2'h0);
      comp_wr_req_in = 3'h7;
      repeat (2) @(posedge clk_in);
      #1;
      chk("eff_off", eff_enable_out, 3'b011);
      chk("wr_off", comp_wr_ok_out, 3'b011);
      do_req(OP_RESTORE, 32'h7, 32'h0, 32'h0, 2'h0);
      flt(1'b1, 1'b0);
      chk("op_off", op_mask_out, 64'h0);
      reset_dut();
      stop_test();
   end

   // Run needs a few hundred cycles; the limit is 20000 cycles
   initial begin
      #(50 * 20000);
      fails++;
      stop_test();
   end

endmodule
